// File: hw/wear_consts.svh
// Shared constants of the breaker wear monitor.
// Assumes inclusion by bare name from hw/ sources.
`ifndef WEAR_CONSTS_SVH
`define WEAR_CONSTS_SVH
`define VW        17
`define LW        13
`define FW        8
`define NW        21
`define NPTS      8
`define CWORDS    16
`define LIM_MIN   17'h00001
`define LIM_MAX   17'h186A0
`define ONE_OP    17'h00001
`define JOB_LAST_CLR 3'h1
`define JOB_LAST_TRIP 3'h4
// APB word indexes (byte address = index * 4)
`define W_CTRL    6'h00
`define W_EVTEN   6'h01
`define W_AL1CUR  6'h02
`define W_AL2CUR  6'h03
`define W_AL1LIM  6'h04
`define W_AL2LIM  6'h05
`define W_STAT    6'h06
`define W_ISTAT   6'h07
`define W_IMASK   6'h08
`define W_OPS0    6'h09
`define W_IBRK0   6'h0F
`define W_IBRK_END 6'h12
`define W_CURVE   2'h2
`define CLR_BIT   0
`endif

// File: hw/wear_pkg.sv
// Types and fixed-point log helpers of the breaker wear monitor.
// Assumes wear_consts.svh is on the include path.
`default_nettype none
`include "wear_consts.svh"
package wear_pkg;
    typedef enum logic [3:0] {
        E_IDLE  = 4'h0,
        E_RCUR  = 4'h1,
        E_RCNT  = 4'h2,
        E_TEST  = 4'h3,
        E_DWAIT = 4'h4,
        E_CALC  = 4'h5,
        E_NEXT  = 4'h6,
        E_APPLY = 4'h7
    } eng_state_type;

    // Base-2 log in 5.8 fixed point, linear mantissa
    function automatic logic [`LW-1:0] lg2(input logic [31:0] x);
        logic [4:0]  p;
        logic [31:0] m;
        p = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (x[i]) p = 5'(i);
        end
        m = x << (5'h1F - p);
        return {p, m[30:23]};
    endfunction

    // Inverse of lg2, result truncated to an integer
    function automatic logic [31:0] ex2(input logic [`LW-1:0] y);
        logic [39:0] v;
        v = {31'h0, 1'b1, y[`FW-1:0]} << y[`LW-1:`FW];
        return v[39:8];
    endfunction
endpackage
`default_nettype wire

// File: hw/wear_if.sv
// Carriers between the wear monitor and its curve store and divider.
// Assumes one clock domain shared by all ends.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
interface curve_bus_if;
    logic           we;
    logic [3:0]     waddr;
    logic [`VW-1:0] wdata;
    logic [3:0]     raddr_a;
    logic [3:0]     raddr_b;
    logic [`VW-1:0] rdata_a;
    logic [`VW-1:0] rdata_b;
    modport ctl (output we, waddr, wdata, raddr_a, raddr_b,
                 input rdata_a, rdata_b);
    modport mem (input we, waddr, wdata, raddr_a, raddr_b,
                 output rdata_a, rdata_b);
endinterface

interface div_bus_if;
    logic           start;
    logic [`NW-1:0] num;
    logic [`LW-1:0] den;
    logic           done;
    logic [`NW-1:0] quo;
    modport ctl (output start, num, den, input done, quo);
    modport dvd (input start, num, den, output done, quo);
endinterface
`default_nettype wire

// File: hw/curve_mem.sv
// Breaker curve store: one write port, two registered read ports.
// Assumes the owner keeps even words as currents, odd as counts.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
module curve_mem #(
    parameter int DEPTH = `CWORDS
) (
    input wire logic mclk,    // system clock
    input wire logic sys_rst, // async reset, active high
    curve_bus_if.mem cb       // curve port
);
    logic [`VW-1:0] mem_r [DEPTH];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) mem_r[i] <= '0;
            cb.rdata_a <= '0;
            cb.rdata_b <= '0;
        end else begin
            if (cb.we) mem_r[cb.waddr] <= cb.wdata;
            cb.rdata_a <= mem_r[cb.raddr_a];
            cb.rdata_b <= mem_r[cb.raddr_b];
        end
    end
endmodule
`default_nettype wire

// File: hw/log_divider.sv
// Sequential restoring divider for the curve exponent.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
module log_divider #(
    parameter int NW = `NW,
    parameter int DW = `LW
) (
    input wire logic mclk,    // system clock
    input wire logic sys_rst, // async reset, active high
    div_bus_if.dvd   dv       // divide request and result
);
    logic [DW-1:0] acc_r;
    logic [NW-1:0] q_r;
    logic [4:0]    cnt_r;
    logic          busy_r;
    logic [DW:0]   trial;

    assign trial = {acc_r, q_r[NW-1]};
    assign dv.quo = q_r;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r   <= '0;
            q_r     <= '0;
            cnt_r   <= 5'h00;
            busy_r  <= 1'b0;
            dv.done <= 1'b0;
        end else begin
            dv.done <= 1'b0;
            if (dv.start && !busy_r) begin
                acc_r  <= '0;
                q_r    <= dv.num;
                cnt_r  <= 5'(NW);
                busy_r <= 1'b1;
            end else if (busy_r) begin
                if (trial >= {1'b0, dv.den}) begin
                    acc_r <= DW'(trial - {1'b0, dv.den});
                    q_r   <= {q_r[NW-2:0], 1'b1};
                end else begin
                    acc_r <= trial[DW-1:0];
                    q_r   <= {q_r[NW-2:0], 1'b0};
                end
                cnt_r <= cnt_r - 5'h01;
                if (cnt_r == 5'h01) begin
                    busy_r  <= 1'b0;
                    dv.done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/breaker_wear_monitor.sv
// Circuit-breaker wear monitor with APB register access.
// Assumes phase currents in amperes, synchronous to mclk.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
// Overview of operation
// - Capture each pole current at trip edge
// - Wear worked out per pole separately
// - Curve holds up to eight points
// - Points after the first with count one are discarded
// - Log interpolation between bounding points
// - Permitted count is a over I^n
// - Two alarms with current and limit
// - Each trip decreases both alarms' counters
// - Three per-phase counters per alarm
// - Alarm watches smallest of three counters
// - Alarm output when minimum below limit
// - Events logged only when enabled
// - Clear reloads counters from curve
// - Below alarm current decrement one
// - Above: decrement is count ratio
// - Limit held within one to 100000
module breaker_wear_monitor #(
    parameter int VW = `VW
) (
    input  wire logic              mclk,           // 20 MHz clock
    input  wire logic              sys_rst,        // async reset
    input  wire logic              psel,           // APB select
    input  wire logic              penable,        // APB enable
    input  wire logic              pwrite,         // APB write
    input  wire logic [7:0]        paddr,          // APB byte addr
    input  wire logic [31:0]       pwdata,         // APB write data
    output var  logic [31:0]       prdata,         // APB read data
    output var  logic              pready,         // APB ready
    output var  logic              pslverr,        // APB error
    input  wire logic              supervised_trip_output, // trip
    input  wire logic [2:0][VW-1:0] phase_current, // pole currents
    output var  logic              alarm1,         // alarm 1 level
    output var  logic              alarm2,         // alarm 2 level
    output var  logic [3:0]        event_pulse,    // logged events
    output var  logic              irq             // interrupt
);
    curve_bus_if cb ();
    div_bus_if   dv ();

    curve_mem u_mem (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .cb      (cb.mem)
    );

    log_divider u_div (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .dv      (dv.dvd)
    );

    wear_pkg::eng_state_type st_r;
    logic [3:0]     evt_en_r;
    logic [VW-1:0]  al_cur_r [2];
    logic [VW-1:0]  al_lim_r [2];
    logic [VW-1:0]  ops_r [6];
    logic [VW-1:0]  ibrk_r [3];
    logic [3:0]     istat_r;
    logic [3:0]     istat_nxt;
    logic [3:0]     imask_r;
    logic           trip_d_r;
    logic           trip_pend_r;
    logic           clear_pend_r;
    logic           trip_mode_r;
    logic [2:0]     job_r;
    logic [2:0]     j_r;
    logic [VW-1:0]  cur_j_r;
    logic [VW-1:0]  ck_r;
    logic [VW-1:0]  ik_r;
    logic [`LW-1:0] lg_ck_r;
    logic [`LW-1:0] lg_ik_r;
    logic [`NW-1:0] n_r;
    logic [`LW-1:0] lgres_r [5];
    logic [VW-1:0]  job_cur;
    logic [`LW-1:0] lg_i;
    logic [`LW-1:0] lg_cnt;
    logic [`LW-1:0] lg_curj;
    logic [`LW-1:0] lg_ckp;
    logic [`LW-1:0] lg_ikp;
    logic [34:0]    prod_k;
    logic [34:0]    prod_i;
    logic [34:0]    base_sum;
    logic [34:0]    lgc_q16;
    logic [`LW-1:0] lgc;
    logic [VW-1:0]  min_ops [2];
    logic           acc_first;
    logic           wr_done;
    logic           rd_done;
    logic           take_clear;
    logic           take_trip;
    logic           trip_edge;
    logic [31:0]    rd_val;
    logic           rd_hit;
    logic [5:0]     widx;

    function automatic logic [VW-1:0] clamp_lim(input logic [31:0] v);
        if (v < 32'(`LIM_MIN)) return `LIM_MIN;
        if (v > 32'(`LIM_MAX)) return `LIM_MAX;
        return v[VW-1:0];
    endfunction

    function automatic logic [VW-1:0] sat(input logic [31:0] v);
        if (|(v >> VW)) return '1;
        return v[VW-1:0];
    endfunction

    // APB handshake: one wait state, pready from a flop
    assign widx      = paddr[7:2];
    assign acc_first = psel && penable && !pready;
    assign wr_done   = psel && penable && pready && pwrite;
    assign rd_done   = psel && penable && pready && !pwrite;
    assign cb.raddr_b = paddr[5:2];
    assign cb.we      = wr_done && (widx[5:4] == `W_CURVE);
    assign cb.waddr   = paddr[5:2];
    assign cb.wdata   = pwdata[VW-1:0];

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (widx[5:4] == `W_CURVE) begin
            rd_val = 32'(cb.rdata_b);
        end else if (widx >= `W_OPS0 && widx < `W_IBRK0) begin
            rd_val = 32'(ops_r[3'(widx - `W_OPS0)]);
        end else if (widx >= `W_IBRK0 && widx < `W_IBRK_END) begin
            rd_val = 32'(ibrk_r[2'(widx - `W_IBRK0)]);
        end else begin
            unique case (widx)
                `W_CTRL:   rd_val = 32'(clear_pend_r);
                `W_EVTEN:  rd_val = 32'(evt_en_r);
                `W_AL1CUR: rd_val = 32'(al_cur_r[0]);
                `W_AL2CUR: rd_val = 32'(al_cur_r[1]);
                `W_AL1LIM: rd_val = 32'(al_lim_r[0]);
                `W_AL2LIM: rd_val = 32'(al_lim_r[1]);
                `W_STAT:   rd_val = 32'({st_r != wear_pkg::E_IDLE,
                                        alarm2, alarm1});
                `W_ISTAT:  rd_val = 32'(istat_r);
                `W_IMASK:  rd_val = 32'(imask_r);
                default:   rd_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= acc_first;
            pslverr <= acc_first && !rd_hit;
            if (acc_first) prdata <= rd_hit ? rd_val : 32'h0000_0000;
        end
    end

    // Settings written by software
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_en_r <= 4'h0;
            imask_r  <= 4'h0;
            for (int a = 0; a < 2; a++) begin
                al_cur_r[a] <= '0;
                al_lim_r[a] <= `LIM_MIN;
            end
        end else if (wr_done) begin
            unique case (widx)
                `W_EVTEN:  evt_en_r    <= pwdata[3:0];
                `W_IMASK:  imask_r     <= pwdata[3:0];
                `W_AL1CUR: al_cur_r[0] <= pwdata[VW-1:0];
                `W_AL2CUR: al_cur_r[1] <= pwdata[VW-1:0];
                `W_AL1LIM: al_lim_r[0] <= clamp_lim(pwdata);
                `W_AL2LIM: al_lim_r[1] <= clamp_lim(pwdata);
                default: ;
            endcase
        end
    end

    // Interrupted current held per pole at the trip edge
    assign trip_edge = supervised_trip_output && !trip_d_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trip_d_r <= 1'b0;
            for (int p = 0; p < 3; p++) ibrk_r[p] <= '0;
        end else begin
            trip_d_r <= supervised_trip_output;
            if (trip_edge) begin
                for (int p = 0; p < 3; p++)
                    ibrk_r[p] <= phase_current[p];
            end
        end
    end

    // Pending work; a new request wins over its take
    assign take_clear = (st_r == wear_pkg::E_IDLE) && clear_pend_r;
    assign take_trip  = (st_r == wear_pkg::E_IDLE) && !clear_pend_r &&
                        trip_pend_r;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trip_pend_r  <= 1'b0;
            clear_pend_r <= 1'b0;
        end else begin
            trip_pend_r  <= trip_edge || (trip_pend_r && !take_trip);
            clear_pend_r <= (wr_done && widx == `W_CTRL &&
                             pwdata[`CLR_BIT]) ||
                            (clear_pend_r && !take_clear);
        end
    end

    // Curve lookup: jobs 0,1 alarm levels, jobs 2..4 pole currents
    always_comb begin
        unique case (job_r)
            3'h0:    job_cur = al_cur_r[0];
            3'h1:    job_cur = al_cur_r[1];
            3'h2:    job_cur = ibrk_r[0];
            3'h3:    job_cur = ibrk_r[1];
            default: job_cur = ibrk_r[2];
        endcase
    end

    assign cb.raddr_a = {j_r, st_r == wear_pkg::E_RCNT};
    assign lg_i    = wear_pkg::lg2(32'(job_cur));
    assign lg_cnt  = wear_pkg::lg2(32'(cb.rdata_a));
    assign lg_curj = wear_pkg::lg2(32'(cur_j_r));
    assign lg_ckp  = wear_pkg::lg2(32'(ck_r));
    assign lg_ikp  = wear_pkg::lg2(32'(ik_r));
    // log a = log Ck + n log Ik; log C = log a - n log I
    assign prod_k   = 35'(n_r) * 35'(lg_ik_r);
    assign prod_i   = 35'(n_r) * 35'(lg_i);
    assign base_sum = {14'h0000, lg_ck_r, 8'h00} + prod_k;
    assign lgc_q16  = (base_sum > prod_i) ? base_sum - prod_i : '0;
    assign lgc = (|lgc_q16[34:21]) ? '1 : lgc_q16[20:8];

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r        <= wear_pkg::E_IDLE;
            trip_mode_r <= 1'b0;
            job_r       <= 3'h0;
            j_r         <= 3'h1;
            cur_j_r     <= '0;
            ck_r        <= '0;
            ik_r        <= '0;
            lg_ck_r     <= '0;
            lg_ik_r     <= '0;
            n_r         <= '0;
            dv.start    <= 1'b0;
            dv.num      <= '0;
            dv.den      <= '0;
            for (int k = 0; k < 5; k++) lgres_r[k] <= '0;
        end else begin
            dv.start <= 1'b0;
            unique case (st_r)
                wear_pkg::E_IDLE: begin
                    if (take_clear || take_trip) begin
                        trip_mode_r <= take_trip;
                        job_r <= 3'h0;
                        j_r   <= 3'h1;
                        st_r  <= wear_pkg::E_RCUR;
                    end
                end
                wear_pkg::E_RCUR: st_r <= wear_pkg::E_RCNT;
                wear_pkg::E_RCNT: begin
                    cur_j_r <= cb.rdata_a;
                    st_r    <= wear_pkg::E_TEST;
                end
                wear_pkg::E_TEST: begin
                    if (j_r != 3'h1 && cb.rdata_a == `ONE_OP) begin
                        lgres_r[job_r] <= lg_ckp;
                        st_r <= wear_pkg::E_NEXT;
                    end else if (cur_j_r > job_cur) begin
                        if (j_r == 3'h1) begin
                            lgres_r[job_r] <= lg_cnt;
                            st_r <= wear_pkg::E_NEXT;
                        end else begin
                            lg_ck_r  <= lg_ckp;
                            lg_ik_r  <= lg_ikp;
                            dv.start <= 1'b1;
                            dv.num   <= (lg_ckp > lg_cnt) ?
                                {lg_ckp - lg_cnt, 8'h00} : '0;
                            dv.den   <= lg_curj - lg_ikp;
                            st_r     <= wear_pkg::E_DWAIT;
                        end
                    end else begin
                        ik_r <= cur_j_r;
                        ck_r <= cb.rdata_a;
                        if (j_r == 3'(`NPTS - 1)) begin
                            lgres_r[job_r] <= lg_cnt;
                            st_r <= wear_pkg::E_NEXT;
                        end else begin
                            j_r  <= j_r + 3'h1;
                            st_r <= wear_pkg::E_RCUR;
                        end
                    end
                end
                wear_pkg::E_DWAIT: begin
                    if (dv.done) begin
                        n_r  <= dv.quo;
                        st_r <= wear_pkg::E_CALC;
                    end
                end
                wear_pkg::E_CALC: begin
                    lgres_r[job_r] <= lgc;
                    st_r <= wear_pkg::E_NEXT;
                end
                wear_pkg::E_NEXT: begin
                    if (job_r == (trip_mode_r ? `JOB_LAST_TRIP :
                                                `JOB_LAST_CLR)) begin
                        st_r <= wear_pkg::E_APPLY;
                    end else begin
                        job_r <= job_r + 3'h1;
                        j_r   <= 3'h1;
                        st_r  <= wear_pkg::E_RCUR;
                    end
                end
                wear_pkg::E_APPLY: st_r <= wear_pkg::E_IDLE;
                default: st_r <= wear_pkg::E_IDLE;
            endcase
        end
    end

    // Operations-left counters, index = alarm * 3 + phase
    for (genvar g = 0; g < 6; g++) begin : g_ops
        localparam int A = g / 3;
        localparam int P = g % 3;
        logic [31:0] dec;
        always_comb begin
            if (ibrk_r[P] < al_cur_r[A]) begin
                dec = 32'h0000_0001;
            end else if (lgres_r[A] > lgres_r[2+P]) begin
                dec = wear_pkg::ex2(lgres_r[A] - lgres_r[2+P]);
            end else begin
                dec = 32'h0000_0001;
            end
        end
        always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
                ops_r[g] <= '0;
            end else if (st_r == wear_pkg::E_APPLY) begin
                if (!trip_mode_r) begin
                    ops_r[g] <= sat(wear_pkg::ex2(lgres_r[A]));
                end else if (32'(ops_r[g]) > dec) begin
                    ops_r[g] <= ops_r[g] - dec[VW-1:0];
                end else begin
                    ops_r[g] <= '0;
                end
            end
        end
    end

    // Smallest per-phase counter of each alarm
    for (genvar a = 0; a < 2; a++) begin : g_min
        logic [VW-1:0] m01;
        assign m01 = (ops_r[3*a] < ops_r[3*a+1]) ? ops_r[3*a] :
                                                   ops_r[3*a+1];
        assign min_ops[a] = (m01 < ops_r[3*a+2]) ? m01 :
                                                   ops_r[3*a+2];
    end

    // Alarm levels and enabled on/off events
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            alarm1      <= 1'b0;
            alarm2      <= 1'b0;
            event_pulse <= 4'h0;
        end else begin
            alarm1 <= min_ops[0] < al_lim_r[0];
            alarm2 <= min_ops[1] < al_lim_r[1];
            event_pulse <= evt_en_r & {
                alarm2 && !(min_ops[1] < al_lim_r[1]),
                !alarm2 && (min_ops[1] < al_lim_r[1]),
                alarm1 && !(min_ops[0] < al_lim_r[0]),
                !alarm1 && (min_ops[0] < al_lim_r[0])};
        end
    end

    // Sticky event status, cleared by reading it; set wins
    always_comb begin
        istat_nxt = istat_r;
        if (rd_done && widx == `W_ISTAT) istat_nxt = 4'h0;
        istat_nxt = istat_nxt | event_pulse;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            istat_r <= 4'h0;
            irq     <= 1'b0;
        end else begin
            istat_r <= istat_nxt;
            irq     <= |(istat_nxt & imask_r);
        end
    end
endmodule
`default_nettype wire

// File: dv/wear_monitor_asserts.sv
// Port-level checks of the breaker wear monitor.
// Assumes binding onto breaker_wear_monitor; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module wear_monitor_asserts (
    input wire logic        mclk,        // system clock
    input wire logic        sys_rst,     // async reset
    input wire logic        psel,        // APB select
    input wire logic        penable,     // APB enable
    input wire logic        pready,      // APB ready
    input wire logic        pslverr,     // APB error
    input wire logic [31:0] prdata,      // APB read data
    input wire logic        alarm1,      // alarm 1 level
    input wire logic        alarm2,      // alarm 2 level
    input wire logic [3:0]  event_pulse  // event strobes
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence wait_s;
        psel && penable ##1 psel && penable;
    endsequence
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("pready long");
    ready_wait_a:
        assert property (wait_s |-> pready) else $error("pready late");
    ready_cause_a:
        assert property (pready |-> $past(psel && penable))
            else $error("pready without access");
    err_ready_a:
        assert property (pslverr |-> pready && prdata == 32'h0)
            else $error("pslverr alone");
    al1_on_a:
        assert property (event_pulse[0] |-> $rose(alarm1))
            else $error("alarm1 on event wrong");
    al1_off_a:
        assert property (event_pulse[1] |-> $fell(alarm1))
            else $error("alarm1 off event wrong");
    al2_on_a:
        assert property (event_pulse[2] |-> $rose(alarm2))
            else $error("alarm2 on event wrong");
    al2_off_a:
        assert property (event_pulse[3] |-> $fell(alarm2))
            else $error("alarm2 off event wrong");
endmodule
bind breaker_wear_monitor wear_monitor_asserts u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .alarm1(alarm1), .alarm2(alarm2), .event_pulse(event_pulse));
`default_nettype wire

// File: dv/trip_source.sv
// Model of the breaker failure trip logic driving the monitor.
// Assumes currents are held steady around each trip.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
module trip_source (
    input  wire logic                mclk,  // system clock
    input  wire logic                fire,  // request one trip
    input  wire logic [2:0][`VW-1:0] level, // currents to break
    output var  logic                trip,  // trip relay level
    output var  logic [2:0][`VW-1:0] cur    // pole currents
);
    logic [2:0] hold_r;
    initial hold_r = 3'h0;
    // Currents settle a cycle before the relay closes
    always_ff @(posedge mclk) begin
        cur <= level;
        hold_r <= fire ? 3'h7 : hold_r >> 1;
    end
    always_comb trip = hold_r[0];
endmodule
`default_nettype wire

// File: dv/test_breaker_wear_monitor.sv
// Self-checking bench of the breaker wear monitor over APB.
// Assumes the trip_source model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "wear_consts.svh"
module test_breaker_wear_monitor;
    logic                mclk, sys_rst, psel, penable, pwrite, fire;
    logic                pready, pslverr, alarm1, alarm2, irq, trip;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd, ops [6];
    logic [3:0]          event_pulse;
    logic [2:0][`VW-1:0] level, cur;
    int                  miscompares, check_count, n;
    int ci [8] = '{0, 1250, 31000, 100000, 100000, 100000, 100000, 100000};
    int cc [8] = '{10000, 10000, 80, 1, 1, 1, 1, 1};
    int dec [3] = '{3, 3, 1};
    breaker_wear_monitor i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supervised_trip_output(trip),
        .phase_current(cur), .alarm1(alarm1), .alarm2(alarm2),
        .event_pulse(event_pulse), .irq(irq));
    trip_source i_src (.mclk(mclk), .fire(fire), .level(level),
        .trip(trip), .cur(cur));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, g,
                       input int t);
        check_count++;
        if (^g === 1'bx || g + t < e || g > e + t) begin
            miscompares++;
            $display("ERROR %s exp %0d got %0d", s, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input int t, input string s);
        apb(1'b0, a, 32'h0);
        chk(s, e, rd, t);
    endtask
    // Lets the engine start, then polls busy
    task automatic settle();
        repeat (6) @(posedge mclk);
        n = 0;
        do begin
            apb(1'b0, 8'h18, 32'h0);
            n++;
        end while (rd[2] !== 1'b0 && n < 300);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #3000000;
        miscompares++;
        finish_test();
    end
    initial begin
        sys_rst = 1'b1;
        {psel, penable, pwrite, fire} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        level = '0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("alarm1 reset", 1, alarm1, 0);
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 8'(8'h80 + 8 * k), ci[k]);
            apb(1'b1, 8'(8'h84 + 8 * k), cc[k]);
        end
        apb(1'b1, 8'h08, 32'd50000);
        apb(1'b1, 8'h0C, 32'd6000);
        apb(1'b1, 8'h10, 32'd80);
        apb(1'b1, 8'h14, 32'h30D40);
        rdc(8'h14, 32'h186A0, 0, "limit high");
        apb(1'b1, 8'h14, 32'h0);
        rdc(8'h14, 32'h1, 0, "limit low");
        apb(1'b1, 8'h04, 32'hF);
        apb(1'b1, 8'h00, 32'h1);
        settle();
        for (int p = 0; p < 6; p++) begin
            apb(1'b0, 8'(8'h24 + 4 * p), 32'h0);
            ops[p] = rd;
            chk("reload", p < 3 ? 80 : 945, rd, p < 3 ? 4 : 47);
        end
        chk("alarm1 clear", 0, alarm1, 0);
        chk("alarm2 clear", 0, alarm2, 0);
        apb(1'b1, 8'h20, 32'h1);
        rdc(8'h1C, 32'hA, 0, "off events");
        level <= {17'd1500, 17'd12500, 17'd12500};
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        settle();
        for (int p = 0; p < 3; p++) begin
            rdc(8'(8'h3C + 4 * p), level[p], 0, "broken");
            rdc(8'(8'h24 + 4 * p), ops[p] - 1, 0, "al1 ops");
            rdc(8'(8'h30 + 4 * p), ops[3 + p] - dec[p], 0, "al2");
        end
        chk("alarm1 trip", 1, alarm1, 0);
        chk("alarm2 trip", 0, alarm2, 0);
        chk("irq set", 1, irq, 0);
        apb(1'b1, 8'h20, 32'h0);
        repeat (2) @(posedge mclk);
        chk("irq masked", 0, irq, 0);
        apb(1'b1, 8'h20, 32'h1);
        rdc(8'h1C, 32'h1, 0, "event status");
        repeat (2) @(posedge mclk);
        chk("irq cleared", 0, irq, 0);
        apb(1'b1, 8'h14, 32'h186A0);
        repeat (2) @(posedge mclk);
        chk("alarm2 limit", 1, alarm2, 0);
        rdc(8'h1C, 32'h4, 0, "al2 event");
        apb(1'b0, 8'h7C, 32'h0);
        chk("unmapped", 0, rd, 0);
        finish_test();
    end
endmodule
`default_nettype wire
